//--- common/ctgs_pkg.sv
// Constants and types shared by the clock trim and pin sync registers
package ctgs_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CONV_FAST_HZ  = 1_000_000;
  localparam int unsigned CONV_SLOW_HZ  = 500_000;
  localparam int unsigned CONV_FAST_CYC = CLK_HZ / CONV_FAST_HZ;
  localparam int unsigned CONV_SLOW_CYC = CLK_HZ / CONV_SLOW_HZ;
  localparam int          CONV_CNT_W    = 6;
  localparam logic [5:0]  CONV_FAST_LAST = 6'(CONV_FAST_CYC - 1);
  localparam logic [5:0]  CONV_SLOW_LAST = 6'(CONV_SLOW_CYC - 1);

  localparam logic [7:0]  ADDR_RATIO  = 8'h0A;
  localparam logic [7:0]  ADDR_TRIM   = 8'h4D;
  localparam logic [7:0]  ADDR_CONV   = 8'h4E;
  localparam logic [7:0]  ADDR_PINCFG = 8'h4F;
  localparam logic [7:0]  ADDR_PINCTL = 8'h50;

  localparam logic [15:0] RST_TRIM    = 16'h0098;
  localparam logic [15:0] RST_CONV    = 16'h0060;
  localparam logic [15:0] RST_PINCFG  = 16'h2090;
  localparam logic [15:0] RST_PINCTL  = 16'h0000;
  localparam logic [15:0] CONV_CODE_FAST = 16'h0040;
  // Host-side registers outside this block, written only by the host
  localparam logic [7:0]  ADDR_STARTUP = 8'h38;
  localparam logic [7:0]  ADDR_CAL_CLK = 8'h5F;
  localparam logic [15:0] STARTUP_WORD = 16'h4000;

  localparam int BIT_P1_OE    = 6;
  localparam int BIT_P1_IE    = 5;
  localparam int SYNC_LSB     = 2;
  localparam int BIT_P0_IE    = 1;
  localparam int BIT_P1_SRC   = 6;
  localparam int BIT_RATIO_GO = 5;
  localparam int TRIM_W       = 8;

  localparam int          RATIO_W     = 12;
  localparam logic [2:0]  RATIO_TICKS_LAST = 3'h3;
  localparam int          SAMPLE_CNT_W = 18;

  localparam int SYNC_W    = 3;
  localparam int SYNC_SLOW = 0;
  localparam int SYNC_PIN0 = 1;
  localparam int SYNC_PIN1 = 2;

  typedef enum logic [1:0] {
    SRC_SLOW_CLOCK,
    SRC_PIN0,
    SRC_PIN1,
    SRC_RESERVED
  } ctgs_sync_src_e;

endpackage

//--- hw/ctgs_sync.sv
// Three-stage synchronisers with agreement filter for external levels
`timescale 1ns/100ps
module ctgs_sync
  import ctgs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [SYNC_W-1:0] async_i,
  output logic      [SYNC_W-1:0] level_o
);
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] lvl_q;
  logic [SYNC_W-1:0] lvl_d;

  // First stage feeds only the second; a change counts once 2 and 3 agree
  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= async_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule // ctgs_sync

//--- hw/ctgs_ratio.sv
// Fast-clock ratio calculation over a window of slow-clock periods
`timescale 1ns/100ps
module ctgs_ratio
  import ctgs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire logic               slow_tick,
  output logic      [RATIO_W-1:0] ratio,
  output logic                    busy
);
  typedef enum logic [1:0] {R_IDLE, R_WAIT, R_COUNT} ctgs_ratio_e;

  ctgs_ratio_e        st_q;
  ctgs_ratio_e        st_d;
  logic [2:0]         ticks_q;
  logic [2:0]         ticks_d;
  logic [RATIO_W-1:0] cnt_q;
  logic [RATIO_W-1:0] cnt_d;
  logic [RATIO_W-1:0] ratio_q;
  logic [RATIO_W-1:0] ratio_d;
  logic               busy_q;
  logic               busy_d;

  always_comb begin
    st_d    = st_q;
    ticks_d = ticks_q;
    cnt_d   = cnt_q;
    ratio_d = ratio_q;
    unique case (st_q)
      R_IDLE: begin
        // A start while busy is dropped; the run in flight finishes
        if (start) begin
          st_d = R_WAIT;
        end
      end
      R_WAIT: begin
        // Align to a slow edge so the window is whole periods
        if (slow_tick) begin
          st_d    = R_COUNT;
          ticks_d = '0;
          cnt_d   = '0;
        end
      end
      R_COUNT: begin
        if (cnt_q != '1) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (slow_tick) begin
          ticks_d = ticks_q + 1'b1;
          if (ticks_q == RATIO_TICKS_LAST) begin
            ratio_d = cnt_d;
            st_d    = R_IDLE;
          end
        end
      end
      default: st_d = R_IDLE;
    endcase
    busy_d = (st_d != R_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= R_IDLE;
      ticks_q <= '0;
      cnt_q   <= '0;
      ratio_q <= '0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      ticks_q <= ticks_d;
      cnt_q   <= cnt_d;
      ratio_q <= ratio_d;
      busy_q  <= busy_d;
    end
  end

  assign ratio = ratio_q;
  assign busy  = busy_q;
endmodule // ctgs_ratio

//--- hw/ctgs_top.sv
// Clock trim, converter clock, pin and sample sync configuration registers
// Behaviour
// - Fast clock trim code, reset 1001 1000
// - Converter clock 1 MHz or 500 kHz
// - Pin 1 driver enabled by bit 6
// - Pin 1 input enabled by bit 5
// - Pin 0 input enabled by bit 1
// - Sync 00 times samples from slow clock
// - Sync 01/10 trigger from pin 0/1
// - Pin 1 drives low or power-down
// - Start bit launches ratio, result at 0x0A
// - Converter speed only in digital integrate mode
`timescale 1ns/100ps
module ctgs_top
  import ctgs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  input  wire logic        SLOW_CLK,
  input  wire logic        DIG_INTEGRATE_MODE,
  input  wire logic [15:0] SAMPLE_PERIOD_COUNT,
  input  wire logic        AFE_POWER_DOWN,
  input  wire logic        AUX_PIN_0_I,
  input  wire logic        AUX_PIN_1_I,
  output logic             AUX_PIN_1_O,
  output logic             AUX_PIN_1_OE_N,
  output logic             PIN0_INPUT_ENABLE,
  output logic             PIN1_INPUT_ENABLE,
  output logic [7:0]       FAST_CLOCK_TRIM,
  output logic             CONV_CLK_TICK,
  output logic             SAMPLE_START,
  output logic             RATIO_BUSY
);

  // Register file state
  logic [15:0] trim_q;
  logic [15:0] trim_d;
  logic [15:0] conv_q;
  logic [15:0] conv_d;
  logic [15:0] pincfg_q;
  logic [15:0] pincfg_d;
  logic [15:0] pinctl_q;
  logic [15:0] pinctl_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        go_q;
  logic        go_d;

  // Pin and trim outputs
  logic        p0_ie_q;
  logic        p0_ie_d;
  logic        p1_ie_q;
  logic        p1_ie_d;
  logic        p1_o_q;
  logic        p1_o_d;
  logic        p1_oe_n_q;
  logic        p1_oe_n_d;
  logic [7:0]  trim_out_q;
  logic [7:0]  trim_out_d;

  // Converter clock tick
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic [CONV_CNT_W-1:0] conv_cnt_d;
  logic [CONV_CNT_W-1:0] conv_last;
  logic                  conv_tick_q;
  logic                  conv_tick_d;

  // Sample timing
  logic [SYNC_W-1:0]       lvl;
  logic [SYNC_W-1:0]       prev_q;
  logic [SYNC_W-1:0]       prev_d;
  logic [SAMPLE_CNT_W-1:0] samp_cnt_q;
  logic [SAMPLE_CNT_W-1:0] samp_cnt_d;
  logic [SAMPLE_CNT_W-1:0] samp_target;
  logic                    samp_start_q;
  logic                    samp_start_d;
  logic                    slow_rise;
  logic                    p0_rise;
  logic                    p1_rise;
  ctgs_sync_src_e          sync_src;

  logic [RATIO_W-1:0] ratio;
  logic               ratio_busy;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_RATIO,
    SEL_TRIM,
    SEL_CONV,
    SEL_PINCFG,
    SEL_PINCTL
  } ctgs_sel_e;

  function automatic ctgs_sel_e addr_decode(input logic [7:0] addr);
    unique case (addr)
      ADDR_RATIO:  return SEL_RATIO;
      ADDR_TRIM:   return SEL_TRIM;
      ADDR_CONV:   return SEL_CONV;
      ADDR_PINCFG: return SEL_PINCFG;
      ADDR_PINCTL: return SEL_PINCTL;
      default:     return SEL_NONE;
    endcase
  endfunction

  function automatic logic rise_of(input logic now_l, input logic was_l);
    return now_l & ~was_l;
  endfunction

  // Pins and slow clock arrive from other domains
  ctgs_sync u_sync (
    .clk     (CLK),
    .rst     (RST),
    .async_i ({AUX_PIN_1_I, AUX_PIN_0_I, SLOW_CLK}),
    .level_o (lvl)
  );

  // Engine sees a registered launch strobe and a tick decoded from registered levels
  ctgs_ratio u_ratio (
    .clk       (CLK),
    .rst       (RST),
    .start     (go_q),
    .slow_tick (slow_rise),
    .ratio     (ratio),
    .busy      (ratio_busy)
  );

  // Register writes and reads
  always_comb begin
    trim_d   = trim_q;
    conv_d   = conv_q;
    pincfg_d = pincfg_q;
    pinctl_d = pinctl_q;
    rdata_d  = rdata_q;
    go_d     = 1'b0;
    if (REG_WR) begin
      unique case (addr_decode(REG_ADDR))
        SEL_TRIM:   trim_d   = REG_WDATA;
        SEL_CONV:   conv_d   = REG_WDATA;
        SEL_PINCFG: pincfg_d = REG_WDATA;
        SEL_PINCTL: begin
          pinctl_d = REG_WDATA;
          // Only the 0 to 1 edge launches a calculation
          go_d = REG_WDATA[BIT_RATIO_GO]
                 & ~pinctl_q[BIT_RATIO_GO];
        end
        // Ratio result is read-only; other codes are not mapped
        SEL_RATIO,
        SEL_NONE:   ;
      endcase
    end
    // Read data holds between reads so the host may fetch it late
    if (REG_RD) begin
      unique case (addr_decode(REG_ADDR))
        SEL_RATIO:  rdata_d = {{(16-RATIO_W){1'b0}}, ratio};
        SEL_TRIM:   rdata_d = trim_q;
        SEL_CONV:   rdata_d = conv_q;
        SEL_PINCFG: rdata_d = pincfg_q;
        SEL_PINCTL: rdata_d = pinctl_q;
        SEL_NONE:   rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      trim_q   <= RST_TRIM;
      conv_q   <= RST_CONV;
      pincfg_q <= RST_PINCFG;
      pinctl_q <= RST_PINCTL;
      rdata_q  <= 16'h0000;
      go_q     <= 1'b0;
    end else begin
      trim_q   <= trim_d;
      conv_q   <= conv_d;
      pincfg_q <= pincfg_d;
      pinctl_q <= pinctl_d;
      rdata_q  <= rdata_d;
      go_q     <= go_d;
    end
  end

  // Pin drivers and buffers follow the configuration
  always_comb begin
    p0_ie_d    = pincfg_q[BIT_P0_IE];
    p1_ie_d    = pincfg_q[BIT_P1_IE];
    p1_oe_n_d  = ~pincfg_q[BIT_P1_OE];
    // Value kept low while undriven so a late enable never glitches high
    p1_o_d     = pincfg_q[BIT_P1_OE] & pinctl_q[BIT_P1_SRC]
                 & AFE_POWER_DOWN;
    trim_out_d = trim_q[TRIM_W-1:0];
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      // Driver off and buffers closed until software opens them
      p0_ie_q    <= 1'b0;
      p1_ie_q    <= 1'b0;
      p1_o_q     <= 1'b0;
      p1_oe_n_q  <= 1'b1;
      trim_out_q <= RST_TRIM[TRIM_W-1:0];
    end else begin
      p0_ie_q    <= p0_ie_d;
      p1_ie_q    <= p1_ie_d;
      p1_o_q     <= p1_o_d;
      p1_oe_n_q  <= p1_oe_n_d;
      trim_out_q <= trim_out_d;
    end
  end

  // Converter clock strobe; unknown codes fall back to the slow rate
  always_comb begin
    if (DIG_INTEGRATE_MODE && conv_q == CONV_CODE_FAST) begin
      conv_last = CONV_FAST_LAST;
    end else begin
      conv_last = CONV_SLOW_LAST;
    end
    // Compare with >= so a shorter period takes hold at once
    conv_tick_d = (conv_cnt_q >= conv_last);
    if (conv_tick_d) begin
      conv_cnt_d = '0;
    end else begin
      conv_cnt_d = conv_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      conv_cnt_q  <= '0;
      conv_tick_q <= 1'b0;
    end else begin
      conv_cnt_q  <= conv_cnt_d;
      conv_tick_q <= conv_tick_d;
    end
  end

  // Sample cycle source
  assign sync_src    = ctgs_sync_src_e'(pincfg_q[SYNC_LSB+1:SYNC_LSB]);
  assign samp_target = {SAMPLE_PERIOD_COUNT, 2'b00};
  assign slow_rise   = rise_of(lvl[SYNC_SLOW], prev_q[SYNC_SLOW]);
  // Triggers pass only while the input buffer is on
  assign p0_rise     = rise_of(lvl[SYNC_PIN0], prev_q[SYNC_PIN0]) & p0_ie_q;
  assign p1_rise     = rise_of(lvl[SYNC_PIN1], prev_q[SYNC_PIN1]) & p1_ie_q;

  always_comb begin
    prev_d       = lvl;
    // Pin modes clear the count so slow mode restarts a whole period
    samp_cnt_d   = '0;
    samp_start_d = 1'b0;
    unique case (sync_src)
      SRC_SLOW_CLOCK: begin
        samp_cnt_d = samp_cnt_q;
        // A zero period count stops sampling rather than racing
        if (slow_rise && samp_target != '0) begin
          if (samp_cnt_q + 1'b1 >= samp_target) begin
            samp_cnt_d   = '0;
            samp_start_d = 1'b1;
          end else begin
            samp_cnt_d = samp_cnt_q + 1'b1;
          end
        end
      end
      SRC_PIN0:     samp_start_d = p0_rise;
      SRC_PIN1:     samp_start_d = p1_rise;
      SRC_RESERVED: samp_start_d = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prev_q       <= '0;
      samp_cnt_q   <= '0;
      samp_start_q <= 1'b0;
    end else begin
      prev_q       <= prev_d;
      samp_cnt_q   <= samp_cnt_d;
      samp_start_q <= samp_start_d;
    end
  end

  // Every output is taken straight from a register
  assign REG_RDATA         = rdata_q;
  assign AUX_PIN_1_O       = p1_o_q;
  assign AUX_PIN_1_OE_N    = p1_oe_n_q;
  assign PIN0_INPUT_ENABLE = p0_ie_q;
  assign PIN1_INPUT_ENABLE = p1_ie_q;
  assign FAST_CLOCK_TRIM   = trim_out_q;
  assign CONV_CLK_TICK     = conv_tick_q;
  assign SAMPLE_START      = samp_start_q;
  assign RATIO_BUSY        = ratio_busy;

endmodule // ctgs_top

//--- verif/ctgs_chk_assertions.sv
// Port assertions for the clock trim and pin sync registers
`timescale 1ns/100ps
module ctgs_chk
  import ctgs_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        AUX_PIN_1_O,
  input wire logic        AUX_PIN_1_OE_N,
  input wire logic        PIN0_INPUT_ENABLE,
  input wire logic        PIN1_INPUT_ENABLE,
  input wire logic [7:0]  FAST_CLOCK_TRIM,
  input wire logic        CONV_CLK_TICK,
  input wire logic        SAMPLE_START,
  input wire logic        RATIO_BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic wcfg;
  logic wctl;
  logic wtrim;
  assign wcfg  = REG_WR && REG_ADDR == ADDR_PINCFG;
  assign wctl  = REG_WR && REG_ADDR == ADDR_PINCTL;
  assign wtrim = REG_WR && REG_ADDR == ADDR_TRIM;
  // Three cycles covers either reading of the two-cycle pin latency
  chk_p1_oe:
  assert property (wcfg |-> ##3
    AUX_PIN_1_OE_N != $past(REG_WDATA[BIT_P1_OE], 3))
    else $error("pin 1 drive enable wrong");
  chk_p1_ie:
  assert property (wcfg |-> ##3
    PIN1_INPUT_ENABLE == $past(REG_WDATA[BIT_P1_IE], 3))
    else $error("pin 1 input enable wrong");
  chk_p0_ie:
  assert property (wcfg |-> ##3
    PIN0_INPUT_ENABLE == $past(REG_WDATA[BIT_P0_IE], 3))
    else $error("pin 0 input enable wrong");
  chk_trim_out:
  assert property (wtrim |-> ##3
    FAST_CLOCK_TRIM == $past(REG_WDATA[7:0], 3))
    else $error("trim code not applied");
  chk_src_low:
  assert property (wctl && !REG_WDATA[BIT_P1_SRC] |-> ##3 !AUX_PIN_1_O)
    else $error("pin 1 not driven low");
  chk_off_low:
  assert property (AUX_PIN_1_OE_N |-> !AUX_PIN_1_O)
    else $error("pin 1 value while undriven");
  chk_tick_gap:
  assert property (CONV_CLK_TICK |=> !CONV_CLK_TICK [*8])
    else $error("converter tick too soon");
  chk_start_one:
  assert property (SAMPLE_START |=> !SAMPLE_START)
    else $error("sample start longer than one cycle");
  chk_busy_cause:
  assert property ($rose(RATIO_BUSY) |-> $past(wctl, 2))
    else $error("ratio busy without control write");
  chk_rst_pins:
  assert property (@(posedge CLK) disable iff (1'b0) RST |->
    AUX_PIN_1_OE_N && !PIN0_INPUT_ENABLE && !PIN1_INPUT_ENABLE)
    else $error("pins enabled in reset");
  cov_busy: cover property ($rose(RATIO_BUSY));
  cov_start: cover property (SAMPLE_START);
  cov_drive: cover property (!AUX_PIN_1_OE_N && AUX_PIN_1_O);
endmodule // ctgs_chk

bind ctgs_top ctgs_chk chk_u (.*);

//--- verif/ctgs_host.sv
// Host model that owns the register port
`timescale 1ns/100ps
module ctgs_host
  import ctgs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic [15:0] REG_RDATA,
  output logic      [7:0]  REG_ADDR,
  output logic      [15:0] REG_WDATA,
  output logic             REG_WR,
  output logic             REG_RD
);
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 16'h0000;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end
  task automatic xfer(input logic [7:0] a, input logic [15:0] d,
                      input logic w, output logic [15:0] q);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = w;
    REG_RD = !w;
    @(posedge CLK);
    #1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    // Released bus shows junk so stale values cannot pass
    REG_ADDR = ~a;
    REG_WDATA = ~d;
    @(posedge CLK);
    q = REG_RDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    xfer(a, 16'h0000, 1'b0, q);
  endtask
  task automatic pins(input logic [15:0] d);
    // Pin-triggered sampling needs the startup word, other sources zero
    wr(ADDR_STARTUP, ^d[3:2] ? STARTUP_WORD : 16'h0000);
    wr(ADDR_PINCFG, RST_PINCFG | (d & 16'h006E));
  endtask
  task automatic cal_clock(input logic en);
    wr(ADDR_CAL_CLK, {15'h0000, en});
  endtask
  task automatic go(input logic [15:0] c);
    wr(ADDR_PINCTL, c);
    wr(ADDR_PINCTL, c | 16'h0020);
  endtask
endmodule // ctgs_host

//--- verif/tb_top.sv
// Self-checking bench for the clock trim and pin sync registers
`timescale 1ns/100ps
module tb_top
  import ctgs_pkg::*;
;
  logic        CLK = 1'b0;
  logic        RST = 1'b0;
  logic        SLOW_CLK = 1'b0;
  logic        DIG_INTEGRATE_MODE = 1'b0;
  logic [15:0] SAMPLE_PERIOD_COUNT = 16'h0000;
  logic        AFE_POWER_DOWN = 1'b0;
  logic        AUX_PIN_0_I = 1'b0;
  logic        AUX_PIN_1_I = 1'b0;
  logic [7:0]  REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic        REG_WR, REG_RD, AUX_PIN_1_O, AUX_PIN_1_OE_N;
  logic        PIN0_INPUT_ENABLE, PIN1_INPUT_ENABLE;
  logic [7:0]  FAST_CLOCK_TRIM;
  logic        CONV_CLK_TICK, SAMPLE_START, RATIO_BUSY;
  int          n_mismatch = 0;
  int          compares = 0;
  int          tc = 0, tgap = 0, sc = 0, sgap = 0, ns = 0;
  ctgs_top dut_u (.*);
  ctgs_host host_u (.*);
  always #25 CLK = ~CLK;
  // Slow clock sped up to 16 cycles a period to keep runs short
  always #400 SLOW_CLK = ~SLOW_CLK;
  always @(posedge CLK) begin
    tc <= CONV_CLK_TICK ? 1 : tc + 1;
    sc <= SAMPLE_START ? 1 : sc + 1;
    if (CONV_CLK_TICK) tgap <= tc;
    if (SAMPLE_START) sgap <= sc;
    if (SAMPLE_START) ns <= ns + 1;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask
  function automatic logic [15:0] pinv();
    return {13'h0, AUX_PIN_1_OE_N, PIN1_INPUT_ENABLE, PIN0_INPUT_ENABLE};
  endfunction
  task automatic t_reset;
    rc(ADDR_TRIM, 16'h0098);
    rc(ADDR_CONV, 16'h0060);
    rc(ADDR_PINCFG, 16'h2090);
    rc(ADDR_PINCTL, 16'h0000);
    rc(ADDR_RATIO, 16'h0000);
    rc(8'h33, 16'h0000);
    chk({8'h0, FAST_CLOCK_TRIM}, 16'h0098);
    chk(pinv(), 16'h0004);
  endtask
  task automatic t_trim;
    logic [15:0] v [3] = '{16'h0000, 16'h00FF, 16'h0098};
    foreach (v[i]) begin
      host_u.wr(ADDR_TRIM, v[i]);
      rc(ADDR_TRIM, v[i]);
      chk({8'h0, FAST_CLOCK_TRIM}, v[i]);
    end
    host_u.wr(ADDR_RATIO, 16'h0FFF);
    rc(ADDR_RATIO, 16'h0000);
  endtask
  task automatic t_conv;
    logic [15:0] c [3] = '{16'h0040, 16'h0060, 16'h0040};
    int p [3] = '{20, 40, 40};
    foreach (c[i]) begin
      host_u.wr(ADDR_CONV, c[i]);
      #1;
      DIG_INTEGRATE_MODE = (i != 2);
      repeat (100) @(posedge CLK);
      chk(16'(tgap), 16'(p[i]));
    end
  endtask
  task automatic t_pins;
    logic [15:0] d [4] = '{16'h0040, 16'h0020, 16'h0002, 16'h0062};
    foreach (d[i]) begin
      host_u.pins(d[i]);
      repeat (3) @(posedge CLK);
      #1;
      chk(pinv(), {13'h0, ~d[i][6], d[i][5], d[i][1]});
    end
    for (int i = 0; i < 3; i++) begin
      host_u.wr(ADDR_PINCTL, i < 2 ? 16'h0040 : 16'h0000);
      #1;
      AFE_POWER_DOWN = (i > 0);
      repeat (3) @(posedge CLK);
      #1;
      chk({15'h0, AUX_PIN_1_O}, {15'h0, i == 1});
    end
    host_u.pins(16'h0020);
    repeat (3) @(posedge CLK);
    #1;
    chk(pinv(), 16'h0006);
  endtask
  task automatic t_sync;
    logic [15:0] d [4] = '{16'h0026, 16'h002A, 16'h002E, 16'h0004};
    int e [4] = '{1, 1, 0, 0};
    int n0;
    #1;
    SAMPLE_PERIOD_COUNT = 16'h0001;
    repeat (300) @(posedge CLK);
    chk(16'(sgap), 16'h0040);
    #1;
    SAMPLE_PERIOD_COUNT = 16'h0000;
    foreach (d[i]) begin
      host_u.pins(d[i]);
      repeat (10) @(posedge CLK);
      n0 = ns;
      #1;
      {AUX_PIN_0_I, AUX_PIN_1_I} = 2'b11;
      repeat (20) @(posedge CLK);
      #1;
      {AUX_PIN_0_I, AUX_PIN_1_I} = 2'b00;
      repeat (20) @(posedge CLK);
      chk(16'(ns - n0), 16'(e[i]));
    end
  endtask
  task automatic t_ratio;
    host_u.cal_clock(1'b1);
    for (int r = 0; r < 2; r++) begin
      host_u.go(16'h0000);
      @(posedge CLK);
      #1;
      chk({15'h0, RATIO_BUSY}, 16'h0001);
      for (int k = 0; k < 200 && RATIO_BUSY !== 1'b0; k++) @(posedge CLK);
      rc(ADDR_RATIO, 16'h0040);
      // A second 1 without clearing first must not relaunch
      host_u.wr(ADDR_PINCTL, 16'h0020);
      #1;
      chk({15'h0, RATIO_BUSY}, 16'h0000);
    end
    host_u.cal_clock(1'b0);
  endtask
  task automatic end_sim;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    end_sim;
  end
  initial begin
    // Raise reset after time zero so the asynchronous clear sees an edge
    #1;
    RST = 1'b1;
    repeat (20) @(posedge CLK);
    #1;
    RST = 1'b0;
    t_reset;
    t_trim;
    t_conv;
    t_pins;
    t_sync;
    t_ratio;
    end_sim;
  end
endmodule // tb_top
